// ---- hdl/spcr_pkg.sv ----
// Constants, field positions and state types of the serial port configuration bank
package spcr_pkg;

  // Register addresses
  localparam logic [12:0] ADDR_CONFIG = 13'h000;
  localparam logic [12:0] ADDR_REVISION = 13'h002;
  localparam logic [12:0] ADDR_VARIANT = 13'h003;
  localparam logic [12:0] ADDR_READBACK = 13'h004;
  localparam logic [12:0] ADDR_EE_STATUS = 13'hB00;
  localparam logic [12:0] ADDR_EE_INTEGRITY = 13'hB01;
  localparam logic [12:0] ADDR_EE_CTRL1 = 13'hB02;
  localparam logic [12:0] ADDR_EE_CTRL2 = 13'hB03;

  // Field positions
  localparam int CFG_DIR_BIT = 7;
  localparam int CFG_LSB_BIT = 6;
  localparam int CFG_SRST_BIT = 5;
  localparam int CFG_MIRROR_BITS = 4;
  localparam int RB_ACTIVE_BIT = 0;
  localparam int EE_BUSY_BIT = 0;
  localparam int EE_ERR_BIT = 0;
  localparam int EE_WEN_BIT = 0;
  localparam int EE_LOAD_BIT = 1;
  localparam int EE_STORE_BIT = 0;
  localparam int INSTR_RW_BIT = 15;

  // Reset values of the control bits
  localparam logic DIR_RST = 1'b0;
  localparam logic LSB_RST = 1'b0;
  localparam logic RB_RST = 1'b0;
  localparam logic EE_WEN_RST = 1'b0;

  // Identity defaults, values arbitrary
  localparam logic [7:0] REVISION_DEFAULT = 8'h5A;
  localparam logic [7:0] VARIANT_DEFAULT = 8'h3C;

  // Transfer counts and checksum seed
  localparam logic [4:0] INSTR_LAST = 5'h0F;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [1:0] EE_IMG_LAST = 2'h2;
  localparam logic [1:0] EE_LOAD_LAST = 2'h3;
  localparam logic [7:0] EE_CHECK_SEED = 8'hA5;

  typedef enum logic [1:0] {
    EE_IDLE = 2'b00,
    EE_STORE = 2'b01,
    EE_LOAD = 2'b10
  } spcr_ee_mode_type;

  typedef struct packed {
    spcr_ee_mode_type mode;
    logic [1:0] cnt;
    logic [7:0] img0;
    logic [7:0] img1;
    logic err;
    logic done;
    logic we;
    logic [1:0] addr;
    logic [7:0] wdata;
  } spcr_ee_state_type;

  typedef struct packed {
    logic sclk_d;
    logic in_instr;
    logic [4:0] icnt;
    logic [15:0] ishift;
    logic rd;
    logic [12:0] addr;
    logic [2:0] bcnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic sdio_out;
    logic sdio_oe_n;
    logic sdo_out;
    logic sdo_oe_n;
    logic dir;
    logic lsb;
    logic srst;
    logic rb_buf;
    logic rb_act;
    logic ee_wen_buf;
    logic ee_wen_act;
    logic ee_load;
    logic ee_store;
  } spcr_state_type;

  localparam spcr_state_type STATE_RST = '{default: '0, in_instr: 1'b1, sdio_oe_n: 1'b1, sdo_oe_n: 1'b1};

endpackage

// ---- hdl/spcr_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module spcr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } spcr_sync_state_type;

  spcr_sync_state_type s_q;
  spcr_sync_state_type s_d;

  always_comb begin
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;
endmodule // spcr_sync

// ---- hdl/spcr_eeprom.sv ----
// EEPROM store and load sequencer with checksum check
`timescale 1ns/100ps
module spcr_eeprom (
  input wire logic clock,
  input wire logic rstn,
  input wire logic store_start,
  input wire logic load_start,
  input wire logic [7:0] img0_in,
  input wire logic [7:0] img1_in,
  output logic busy,
  output logic data_error,
  output logic load_done,
  output logic [7:0] load_img0,
  output logic [7:0] load_img1,
  output logic [1:0] ee_addr,
  output logic [7:0] ee_wdata,
  output logic ee_we,
  input wire logic [7:0] ee_rdata
);
  import spcr_pkg::*;

  spcr_ee_state_type s_q;
  spcr_ee_state_type s_d;
  logic [7:0] check;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.we = 1'b0;
    check = s_q.img0 ^ s_q.img1 ^ EE_CHECK_SEED;
    case (s_q.mode)
      EE_IDLE: begin
        if (store_start) begin
          s_d.mode = EE_STORE;
          s_d.cnt = 2'h0;
          s_d.img0 = img0_in;
          s_d.img1 = img1_in;
        end else if (load_start) begin
          s_d.mode = EE_LOAD;
          s_d.cnt = 2'h0;
          s_d.err = 1'b0;
        end
      end
      EE_STORE: begin
        // Image bytes then checksum, one write per cycle
        s_d.we = 1'b1;
        s_d.addr = s_q.cnt;
        s_d.wdata = (s_q.cnt == 2'h0) ? s_q.img0 : ((s_q.cnt == 2'h1) ? s_q.img1 : check);
        s_d.cnt = s_q.cnt + 2'h1;
        if (s_q.cnt == EE_IMG_LAST) begin
          s_d.mode = EE_IDLE;
        end
      end
      EE_LOAD: begin
        // Read data belongs to the address issued one cycle earlier
        s_d.addr = s_q.cnt;
        s_d.cnt = s_q.cnt + 2'h1;
        if (s_q.cnt == 2'h1) begin
          s_d.img0 = ee_rdata;
        end
        if (s_q.cnt == EE_IMG_LAST) begin
          s_d.img1 = ee_rdata;
        end
        if (s_q.cnt == EE_LOAD_LAST) begin
          s_d.mode = EE_IDLE;
          if (ee_rdata != check) begin
            s_d.err = 1'b1;
          end else begin
            s_d.done = 1'b1;
          end
        end
      end
      default: begin
        s_d.mode = EE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = (s_q.mode != EE_IDLE);
  assign data_error = s_q.err;
  assign load_done = s_q.done;
  assign load_img0 = s_q.img0;
  assign load_img1 = s_q.img1;
  assign ee_addr = s_q.addr;
  assign ee_wdata = s_q.wdata;
  assign ee_we = s_q.we;
endmodule // spcr_eeprom

// ---- hdl/spcr_port_regs.sv ----
// Serial port slave with configuration, identity and EEPROM control registers
`timescale 1ns/100ps
// Functional notes
// - Direction bit 0: shared data pin carries both ways, output pin floats.
// - Direction bit 1: writes on shared pin, reads only on output pin.
// - Order bit 0: MSB first, address steps down in multibyte transfers.
// - Order bit 1: LSB first, address steps up in multibyte transfers.
// - In I2C mode the order and stepping setting is ignored.
// - Writing soft reset restores the direction, order, readback select and EEPROM write enable bits to their defaults.
// - Soft reset bit clears itself on the next serial clock after the write.
// - Read-only byte reports the silicon revision.
// - Read-only byte identifies the product variant.
// - Readback select 0 returns buffer registers on reads.
// - Readback select 1 returns active registers on reads.
module spcr_port_regs #(
  parameter logic [7:0] REVISION_ID = spcr_pkg::REVISION_DEFAULT,
  parameter logic [7:0] VARIANT_ID = spcr_pkg::VARIANT_DEFAULT
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  output logic dedicated_data_output_pin,
  output logic dedicated_data_output_pin_oe_n,
  input wire logic i2c_mode,
  input wire logic io_update,
  output logic data_direction_select,
  output logic lsb_first,
  output logic soft_reset,
  output logic readback_active,
  output logic [1:0] ee_addr,
  output logic [7:0] ee_wdata,
  output logic ee_we,
  input wire logic [7:0] ee_rdata
);
  import spcr_pkg::*;

  spcr_state_type s_q;
  spcr_state_type s_d;
  logic [3:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic sdio_s;
  logic i2c_s;
  logic lsb_eff;
  logic rise;
  logic fall;
  logic ee_busy;
  logic ee_err;
  logic ee_done;
  logic [7:0] ee_img0;
  logic [7:0] ee_img1;
  logic [7:0] img0_out;
  logic [7:0] img1_out;
  logic [15:0] iw;
  logic [7:0] rb;
  logic [12:0] na;
  logic out_bit;

  spcr_sync #(
    .WIDTH(4)
  ) u_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in({i2c_mode, sdio_in, cs_n, sclk}),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign cs_n_s = pins_s[1];
  assign sdio_s = pins_s[2];
  assign i2c_s = pins_s[3];

  assign lsb_eff = s_q.lsb & ~i2c_s;
  assign rise = ~cs_n_s & sclk_s & ~s_q.sclk_d;
  assign fall = ~cs_n_s & ~sclk_s & s_q.sclk_d;

  // Image kept in EEPROM: config high bits and readback select
  always_comb begin
    img0_out = 8'h00;
    img0_out[CFG_DIR_BIT] = s_q.dir;
    img0_out[CFG_LSB_BIT] = s_q.lsb;
    img1_out = 8'h00;
    img1_out[RB_ACTIVE_BIT] = s_q.rb_buf;
  end

  spcr_eeprom u_eeprom (
    .clock(clock),
    .rstn(rstn),
    .store_start(s_q.ee_store),
    .load_start(s_q.ee_load),
    .img0_in(img0_out),
    .img1_in(img1_out),
    .busy(ee_busy),
    .data_error(ee_err),
    .load_done(ee_done),
    .load_img0(ee_img0),
    .load_img1(ee_img1),
    .ee_addr(ee_addr),
    .ee_wdata(ee_wdata),
    .ee_we(ee_we),
    .ee_rdata(ee_rdata)
  );

  function automatic logic [7:0] read_byte(input logic [12:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_CONFIG) begin
      v[CFG_DIR_BIT] = s_q.dir;
      v[CFG_LSB_BIT] = s_q.lsb;
      v[CFG_SRST_BIT] = s_q.srst;
      for (int i = 0; i < CFG_MIRROR_BITS; i++) begin
        v[i] = v[7 - i];
      end
    end else if (a == ADDR_REVISION) begin
      v = REVISION_ID;
    end else if (a == ADDR_VARIANT) begin
      v = VARIANT_ID;
    end else if (a == ADDR_READBACK) begin
      v[RB_ACTIVE_BIT] = s_q.rb_act ? s_q.rb_act : s_q.rb_buf;
    end else if (a == ADDR_EE_STATUS) begin
      v[EE_BUSY_BIT] = ee_busy;
    end else if (a == ADDR_EE_INTEGRITY) begin
      v[EE_ERR_BIT] = ee_err;
    end else if (a == ADDR_EE_CTRL1) begin
      v[EE_WEN_BIT] = s_q.rb_act ? s_q.ee_wen_act : s_q.ee_wen_buf;
      v[EE_LOAD_BIT] = s_q.ee_load;
    end else if (a == ADDR_EE_CTRL2) begin
      v[EE_STORE_BIT] = s_q.ee_store;
    end
    return v;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.sclk_d = sclk_s;
    s_d.ee_store = 1'b0;
    s_d.ee_load = 1'b0;
    out_bit = 1'b0;
    // Shift direction follows the bit order
    iw = lsb_eff ? {sdio_s, s_q.ishift[15:1]} : {s_q.ishift[14:0], sdio_s};
    rb = lsb_eff ? {sdio_s, s_q.rx[7:1]} : {s_q.rx[6:0], sdio_s};
    na = lsb_eff ? (s_q.addr + 13'h001) : (s_q.addr - 13'h001);

    // Buffered bits move to active on update
    if (io_update) begin
      s_d.rb_act = s_q.rb_buf;
      s_d.ee_wen_act = s_q.ee_wen_buf;
    end

    // Settings restored from EEPROM
    if (ee_done) begin
      s_d.dir = ee_img0[CFG_DIR_BIT];
      s_d.lsb = ee_img0[CFG_LSB_BIT];
      s_d.rb_buf = ee_img1[RB_ACTIVE_BIT];
      s_d.rb_act = ee_img1[RB_ACTIVE_BIT];
    end

    if (cs_n_s) begin
      s_d.in_instr = 1'b1;
      s_d.icnt = 5'h00;
      s_d.bcnt = 3'h0;
      s_d.sdio_oe_n = 1'b1;
      s_d.sdo_oe_n = 1'b1;
    end else begin
      if (rise) begin
        if (s_q.srst) begin
          s_d.srst = 1'b0;
        end
        if (s_q.in_instr) begin
          s_d.ishift = iw;
          s_d.icnt = s_q.icnt + 5'h01;
          if (s_q.icnt == INSTR_LAST) begin
            s_d.in_instr = 1'b0;
            s_d.rd = iw[INSTR_RW_BIT];
            s_d.addr = iw[12:0];
            s_d.bcnt = 3'h0;
            s_d.tx = read_byte(iw[12:0]);
          end
        end else begin
          s_d.rx = rb;
          s_d.bcnt = s_q.bcnt + 3'h1;
          if (s_q.bcnt == BYTE_LAST) begin
            s_d.addr = na;
            if (s_q.rd) begin
              s_d.tx = read_byte(na);
            end else if (s_q.addr == ADDR_CONFIG) begin
              // Only the high nibble is used; the mirror nibble is redundant
              if (rb[CFG_SRST_BIT]) begin
                s_d.dir = DIR_RST;
                s_d.lsb = LSB_RST;
                s_d.rb_buf = RB_RST;
                s_d.rb_act = RB_RST;
                s_d.ee_wen_buf = EE_WEN_RST;
                s_d.ee_wen_act = EE_WEN_RST;
                s_d.srst = 1'b1;
              end else begin
                s_d.dir = rb[CFG_DIR_BIT];
                s_d.lsb = rb[CFG_LSB_BIT];
              end
            end else if (s_q.addr == ADDR_READBACK) begin
              s_d.rb_buf = rb[RB_ACTIVE_BIT];
            end else if (s_q.addr == ADDR_EE_CTRL1) begin
              s_d.ee_wen_buf = rb[EE_WEN_BIT];
              s_d.ee_load = rb[EE_LOAD_BIT];
            end else if (s_q.addr == ADDR_EE_CTRL2) begin
              s_d.ee_store = rb[EE_STORE_BIT] & s_q.ee_wen_act;
            end
          end
        end
      end
      if (fall && !s_q.in_instr && s_q.rd) begin
        out_bit = lsb_eff ? s_q.tx[s_q.bcnt] : s_q.tx[BYTE_LAST - s_q.bcnt];
        if (s_q.dir) begin
          s_d.sdo_out = out_bit;
          s_d.sdo_oe_n = 1'b0;
          s_d.sdio_oe_n = 1'b1;
        end else begin
          s_d.sdio_out = out_bit;
          s_d.sdio_oe_n = 1'b0;
          s_d.sdo_oe_n = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign sdio_out = s_q.sdio_out;
  assign sdio_oe_n = s_q.sdio_oe_n;
  assign dedicated_data_output_pin = s_q.sdo_out;
  assign dedicated_data_output_pin_oe_n = s_q.sdo_oe_n;
  assign data_direction_select = s_q.dir;
  assign lsb_first = s_q.lsb;
  assign soft_reset = s_q.srst;
  assign readback_active = s_q.rb_act;
endmodule // spcr_port_regs

// ---- sim/spcr_port_regs_monitor.sv ----
// Concurrent checks on the ports of the serial port bank
`timescale 1ns/100ps
module spcr_port_regs_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic io_update,
  input wire logic sdio_oe_n,
  input wire logic dedicated_data_output_pin_oe_n,
  input wire logic data_direction_select,
  input wire logic lsb_first,
  input wire logic soft_reset,
  input wire logic readback_active,
  input wire logic ee_we,
  input wire logic [1:0] ee_addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Two image bytes and the checksum written back to back
  sequence s_store;
    ee_addr == 2'h0 ##1 ee_we && ee_addr == 2'h1 ##1 ee_we && ee_addr == 2'h2 ##1 !ee_we;
  endsequence
  property p_sdo_float;
    !data_direction_select |-> dedicated_data_output_pin_oe_n;
  endproperty
  property p_uni_sdio;
    data_direction_select |-> sdio_oe_n;
  endproperty
  property p_release;
    $rose(cs_n) |-> ##[1:6] sdio_oe_n && dedicated_data_output_pin_oe_n;
  endproperty
  property p_srst_clear;
    $rose(soft_reset) |-> ##[0:1] !data_direction_select && !lsb_first && !readback_active;
  endproperty
  property p_srst_self;
    soft_reset && $rose(sclk) |-> ##[1:5] !soft_reset;
  endproperty
  property p_store;
    $rose(ee_we) |-> s_store;
  endproperty
  property p_store_cause;
    $rose(ee_we) |-> $past(!cs_n, 5);
  endproperty
  property p_rb_cause;
    $changed(readback_active) |-> $past(io_update) || soft_reset || ee_addr == 2'h3;
  endproperty
  a_sdo_float: assert property (p_sdo_float) else $error("output pin driven in shared mode");
  a_uni_sdio: assert property (p_uni_sdio) else $error("shared pin driven in split mode");
  a_release: assert property (p_release) else $error("pins not released");
  a_srst_clear: assert property (p_srst_clear) else $error("soft reset kept settings");
  a_srst_self: assert property (p_srst_self) else $error("soft reset bit stuck");
  a_store: assert property (p_store) else $error("bad store sequence");
  a_store_cause: assert property (p_store_cause) else $error("store outside transfer");
  a_rb_cause: assert property (p_rb_cause) else $error("readback select changed alone");
endmodule // spcr_port_regs_monitor

bind spcr_port_regs spcr_port_regs_monitor u_mon (.clock, .rstn, .sclk, .cs_n, .io_update, .sdio_oe_n,
  .dedicated_data_output_pin_oe_n, .data_direction_select, .lsb_first, .soft_reset, .readback_active,
  .ee_we, .ee_addr);

// ---- sim/spcr_host.sv ----
// Serial host model driving the port pins
`timescale 1ns/100ps
module spcr_host (
  input wire logic clock,
  output logic sclk,
  output logic cs_n,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  input wire logic ddo,
  input wire logic ddo_oe_n
);
  logic hv = 1'b0;
  logic rel = 1'b0;
  logic uni = 1'b0;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // Released line toggles so stale data never matches
  always @(posedge clock) if (rel) hv <= ~hv;
  assign sdio_in = sdio_oe_n ? hv : sdio_out;
  task automatic bitx(input logic b, input logic drv, output logic r);
    @(posedge clock) sclk <= 1'b0;
    if (drv) hv <= b;
    else rel <= 1'b1;
    repeat (4) @(posedge clock);
    sclk <= 1'b1;
    repeat (3) @(posedge clock);
    // Released pins show the toggling line, so a missing enable is caught
    #1 r = uni ? (ddo_oe_n ? hv : ddo) : sdio_in;
  endtask
  task automatic xfer(input logic rd, input logic [12:0] a, input logic lsb, input int n,
    input logic [31:0] wd, output logic [31:0] q);
    logic [15:0] w;
    logic r;
    w = {rd, 2'b00, a};
    q = '0;
    @(posedge clock) cs_n <= 1'b0;
    for (int i = 0; i < 16; i++) bitx(lsb ? w[i] : w[15-i], 1'b1, r);
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i++) begin
        bitx(lsb ? wd[8*k+i] : wd[8*k+7-i], !rd, r);
        q[8*k+(lsb ? i : 7-i)] = r;
      end
    end
    @(posedge clock) sclk <= 1'b0;
    repeat (4) @(posedge clock);
    cs_n <= 1'b1;
    rel <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
endmodule // spcr_host

// ---- sim/test_serial_port_config_regs.sv ----
// Self-checking bench of the serial port configuration bank
`timescale 1ns/100ps
module test_serial_port_config_regs;
  import spcr_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic io_update = 1'b0;
  logic ord = 1'b0;
  logic i2c = 1'b0;
  logic sclk, cs_n, sdio_in, sdio_out, sdio_oe_n, ddo, ddo_oe_n, dir, lsb, srst, rba, ee_we;
  logic [1:0] ee_addr;
  logic [7:0] ee_wdata;
  logic [7:0] v;
  logic [7:0] mem [4] = '{default: 8'h00};
  logic [31:0] q;
  int failures = 0;
  int compares = 0;
  int nwe = 0;
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    if (ee_we) begin
      mem[ee_addr] <= ee_wdata;
      nwe++;
    end
  end
  spcr_port_regs DUT (.clock(clock), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .dedicated_data_output_pin(ddo),
    .dedicated_data_output_pin_oe_n(ddo_oe_n), .i2c_mode(i2c), .io_update(io_update),
    .data_direction_select(dir), .lsb_first(lsb), .soft_reset(srst), .readback_active(rba),
    .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_we(ee_we), .ee_rdata(mem[ee_addr]));
  spcr_host host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .ddo(ddo), .ddo_oe_n(ddo_oe_n));
  // Low nibble is the bit-reversed high nibble
  function automatic logic [7:0] mir(input logic [7:0] h);
    return {h[7:4], h[4], h[5], h[6], h[7]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, ord, 1, {24'h0, d}, q);
  endtask
  task automatic rd(input logic [12:0] a, input int n);
    host.xfer(1'b1, a, ord, n, 32'h0, q);
  endtask
  task automatic upd();
    @(posedge clock) io_update <= 1'b1;
    @(posedge clock) io_update <= 1'b0;
    @(posedge clock);
  endtask
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #2000000;
    failures++;
    results();
  end
  initial begin
    void'($urandom(32'h1196));
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(ADDR_CONFIG, 1);
    check(q, 32'h0);
    rd(ADDR_VARIANT, 2);
    check(q[15:0], {REVISION_DEFAULT, VARIANT_DEFAULT});
    $display("defaults done");
    wr(ADDR_CONFIG, mir(8'h40));
    ord = 1'b1;
    check(lsb, 1'b1);
    rd(ADDR_REVISION, 2);
    check(q[15:0], {VARIANT_DEFAULT, REVISION_DEFAULT});
    rd(ADDR_CONFIG, 1);
    check(q[7:0], mir(8'h40));
    @(posedge clock) i2c <= 1'b1;
    ord = 1'b0;
    rd(ADDR_VARIANT, 2);
    check(q[15:0], {REVISION_DEFAULT, VARIANT_DEFAULT});
    @(posedge clock) i2c <= 1'b0;
    ord = 1'b1;
    $display("order done");
    wr(ADDR_CONFIG, mir(8'hC0));
    host.uni = 1'b1;
    rd(ADDR_VARIANT, 1);
    check(q[7:0], VARIANT_DEFAULT);
    rd(13'h001, 1);
    check(q[7:0], 8'h00);
    v = 8'($urandom) | 8'h01;
    wr(ADDR_READBACK, v);
    rd(ADDR_READBACK, 1);
    check(q[7:0], 8'h01);
    upd();
    check(rba, 1'b1);
    wr(ADDR_READBACK, ~v);
    rd(ADDR_READBACK, 1);
    check(q[7:0], 8'h01);
    upd();
    rd(ADDR_READBACK, 1);
    check(q[7:0], 8'h00);
    $display("readback done");
    wr(ADDR_CONFIG, mir(8'hE0));
    check({srst, dir, lsb, rba}, 4'b1000);
    ord = 1'b0;
    host.uni = 1'b0;
    rd(ADDR_CONFIG, 1);
    check({srst, q[7:0]}, 9'h000);
    $display("soft reset done");
    wr(ADDR_EE_CTRL2, 8'h01);
    check(nwe, 0);
    wr(ADDR_EE_CTRL1, 8'h01);
    upd();
    wr(ADDR_EE_CTRL2, 8'h01);
    check(nwe, 3);
    check(mem[2], mem[0] ^ mem[1] ^ EE_CHECK_SEED);
    rd(ADDR_EE_STATUS, 1);
    check(q[7:0], 8'h00);
    wr(ADDR_EE_CTRL1, 8'h02);
    rd(ADDR_EE_INTEGRITY, 1);
    check(q[7:0], 8'h00);
    rd(ADDR_EE_CTRL1, 1);
    check(q[7:0], 8'h00);
    mem[2] = ~mem[2];
    wr(ADDR_EE_CTRL1, 8'h02);
    rd(ADDR_EE_INTEGRITY, 1);
    check(q[7:0], 8'h01);
    $display("eeprom done");
    results();
  end
endmodule // test_serial_port_config_regs
